// File: hdl/core_ops_pkg.sv
// constants and encodings shared by the instruction execution core
// Notes on behaviour
// - file address 0..127; dest bit picks working/file
// - increment file to destination, only zero flag
// - working OR file to destination, only zero
// - copy file to destination, zero flag follows
// - literal into working, flags untouched
// - working stored into addressed file, flags untouched
// - return literal: literal to working, pc from stack
// - return literal takes pc from stack top
// - plain return pops stack into pc
// - all three returns take two instruction cycles
// - interrupt return loads pc, sets interrupt enable
package core_ops_pkg;
  // data path widths
  localparam int DATA_W = 8;
  localparam int FILE_AW = 7;
  localparam int FILE_DEPTH = 128;
  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_AW = 3;
  localparam int OP_W = 4;
  localparam int REG_AW = 2;

  // instruction codes presented on the op port
  localparam logic [OP_W-1:0] OP_NOP = 4'h0;
  localparam logic [OP_W-1:0] OP_INCREMENT_FILE = 4'h1;
  localparam logic [OP_W-1:0] OP_OR_WORKING_INTO_FILE = 4'h2;
  localparam logic [OP_W-1:0] OP_COPY_FILE_TO_DEST = 4'h3;
  localparam logic [OP_W-1:0] OP_LOAD_LITERAL_TO_WORKING = 4'h4;
  localparam logic [OP_W-1:0] OP_STORE_WORKING_TO_FILE = 4'h5;
  localparam logic [OP_W-1:0] OP_RETURN_WITH_LITERAL = 4'h6;
  localparam logic [OP_W-1:0] OP_RETURN_PLAIN = 4'h7;
  localparam logic [OP_W-1:0] OP_RETURN_FROM_INTERRUPT = 4'h8;

  // destination select values
  localparam logic DEST_WORKING = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // register port map
  localparam logic [REG_AW-1:0] REG_WORKING = 2'h0;
  localparam logic [REG_AW-1:0] REG_STATUS = 2'h1;
  localparam logic [REG_AW-1:0] REG_PC_LOW = 2'h2;
  localparam logic [REG_AW-1:0] REG_PC_HIGH = 2'h3;

  // status register field positions
  localparam int STAT_ZERO_BIT = 0;
  localparam int STAT_INT_EN_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int PC_HIGH_W = PC_W - DATA_W;

  // reset values, then constant bytes and pc/stack step sizes
  localparam logic [DATA_W-1:0] WORKING_RST = 8'h00;
  localparam logic [DATA_W-1:0] FILE_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [STACK_AW-1:0] SP_RST = 3'h0;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] ONE_BYTE = 8'h01;
  localparam logic [PC_W-1:0] PC_STEP = 13'h0001;
  localparam logic [STACK_AW-1:0] SP_STEP = 3'h1;

  // execution sequencer states, one-hot
  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } exec_state_e;
endpackage : core_ops_pkg

// File: hdl/file_regs.sv
// file register storage: 128 bytes of flip-flops, one read and one write port
`timescale 1ns/1ps
module file_regs (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // read port, combinational
  input wire logic [core_ops_pkg::FILE_AW-1:0] rd_addr_i,
  output logic [core_ops_pkg::DATA_W-1:0] rd_data_o,
  // write port
  input wire logic wr_en_i,
  input wire logic [core_ops_pkg::FILE_AW-1:0] wr_addr_i,
  input wire logic [core_ops_pkg::DATA_W-1:0] wr_data_i
);
  // storage array indexed by the file address
  logic [core_ops_pkg::DATA_W-1:0] mem_q [core_ops_pkg::FILE_DEPTH];

  // read is asynchronous so an operation reads and writes in one cycle
  assign rd_data_o = mem_q[rd_addr_i];

  // clear all bytes on reset, else write the addressed byte
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < core_ops_pkg::FILE_DEPTH; i++) begin
        mem_q[i] <= core_ops_pkg::FILE_RST;
      end
    end else if (wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end
endmodule : file_regs

// File: hdl/return_stack.sv
// eight-level return address stack; pointer wraps like the hardware it models
`timescale 1ns/1ps
module return_stack (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // push from call logic, pop from returns
  input wire logic push_i,
  input wire logic [core_ops_pkg::PC_W-1:0] push_data_i,
  input wire logic pop_i,
  // current top entry
  output logic [core_ops_pkg::PC_W-1:0] top_of_stack_entry_o
);
  // entries and next-free pointer
  logic [core_ops_pkg::PC_W-1:0] mem_q [core_ops_pkg::STACK_DEPTH];
  logic [core_ops_pkg::STACK_AW-1:0] sp_q;
  logic [core_ops_pkg::STACK_AW-1:0] top_idx;

  // top sits one below the next-free slot; overflow silently wraps
  assign top_idx = sp_q - core_ops_pkg::SP_STEP;
  assign top_of_stack_entry_o = mem_q[top_idx];

  // pop wins over push; a push arriving in the same cycle as a pop is dropped
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sp_q <= core_ops_pkg::SP_RST;
      for (int i = 0; i < core_ops_pkg::STACK_DEPTH; i++) begin
        mem_q[i] <= core_ops_pkg::PC_RST;
      end
    end else if (pop_i) begin
      sp_q <= top_idx;
    end else if (push_i) begin
      mem_q[sp_q] <= push_data_i;
      sp_q <= sp_q + core_ops_pkg::SP_STEP;
    end
  end
endmodule : return_stack

// File: hdl/move_or_increment_return_ops.sv
// execution core for increment, or, moves, literal load and the three returns
`timescale 1ns/1ps
module move_or_increment_return_ops (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // instruction issue
  input wire logic instr_valid_i,
  input wire logic [core_ops_pkg::OP_W-1:0] instr_op_i,
  input wire logic [core_ops_pkg::FILE_AW-1:0] file_addr_i,
  input wire logic dest_sel_i,
  input wire logic [core_ops_pkg::DATA_W-1:0] literal_i,
  output logic instr_ready_o,
  output logic retire_o,
  // return address push from call logic
  input wire logic call_push_i,
  input wire logic [core_ops_pkg::PC_W-1:0] call_addr_i,
  // architectural state
  output logic [core_ops_pkg::DATA_W-1:0] working_o,
  output logic zero_o,
  output logic global_interrupt_enable_o,
  output logic [core_ops_pkg::PC_W-1:0] pc_o,
  // register port
  input wire logic [core_ops_pkg::REG_AW-1:0] reg_addr_i,
  input wire logic [core_ops_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [core_ops_pkg::DATA_W-1:0] reg_rdata_o
);

  // zero test, used for the zero flag update of the three destination ops
  function automatic logic is_zero(input logic [core_ops_pkg::DATA_W-1:0] v);
    is_zero = (v == core_ops_pkg::ZERO_BYTE);
  endfunction : is_zero

  // opcode compare, used by every opcode decode wire
  function automatic logic op_is(input logic [core_ops_pkg::OP_W-1:0] op,
                                 input logic [core_ops_pkg::OP_W-1:0] code);
    op_is = (op == code);
  endfunction : op_is

  // sequencer and architectural registers
  core_ops_pkg::exec_state_e state_q, state_d;
  logic [core_ops_pkg::DATA_W-1:0] working_q, working_d;
  logic zero_q, zero_d;
  logic int_en_q, int_en_d;
  logic [core_ops_pkg::PC_W-1:0] pc_q, pc_d;
  logic ready_q;
  logic retire_q, retire_d;
  logic [core_ops_pkg::DATA_W-1:0] rdata_q, rdata_d;

  // decode wires
  logic accept;
  logic is_inc, is_or, is_copy, is_load, is_store;
  logic is_ret_lit, is_ret, is_reti;
  logic writes_result; // op with a destination select
  logic pop;           // any of the three returns
  logic to_file;       // file register write this cycle
  logic to_working;    // result routed to working
  logic sw_wr_working, sw_wr_status;

  // datapath wires
  logic [core_ops_pkg::DATA_W-1:0] file_rd;
  logic [core_ops_pkg::DATA_W-1:0] inc_sum;
  logic [core_ops_pkg::DATA_W-1:0] or_val;
  logic [core_ops_pkg::DATA_W-1:0] alu_res;
  logic [core_ops_pkg::DATA_W-1:0] file_wdata;
  logic [core_ops_pkg::PC_W-1:0] stack_top;
  logic [core_ops_pkg::DATA_W-1:0] status_view;

  // an instruction is taken only while the sequencer is not flushing
  assign accept = instr_valid_i & (state_q == core_ops_pkg::ST_EXEC);
  assign is_inc = accept & op_is(instr_op_i, core_ops_pkg::OP_INCREMENT_FILE);
  assign is_or = accept & op_is(instr_op_i, core_ops_pkg::OP_OR_WORKING_INTO_FILE);
  assign is_copy = accept & op_is(instr_op_i, core_ops_pkg::OP_COPY_FILE_TO_DEST);
  assign is_load = accept & op_is(instr_op_i, core_ops_pkg::OP_LOAD_LITERAL_TO_WORKING);
  assign is_store = accept & op_is(instr_op_i, core_ops_pkg::OP_STORE_WORKING_TO_FILE);
  assign is_ret_lit = accept & op_is(instr_op_i, core_ops_pkg::OP_RETURN_WITH_LITERAL);
  assign is_ret = accept & op_is(instr_op_i, core_ops_pkg::OP_RETURN_PLAIN);
  assign is_reti = accept & op_is(instr_op_i, core_ops_pkg::OP_RETURN_FROM_INTERRUPT);
  assign writes_result = is_inc | is_or | is_copy;
  assign pop = is_ret_lit | is_ret | is_reti;

  assign to_file = (writes_result & (dest_sel_i == core_ops_pkg::DEST_FILE)) | is_store;
  assign to_working = writes_result & (dest_sel_i == core_ops_pkg::DEST_WORKING);

  assign inc_sum = file_rd + core_ops_pkg::ONE_BYTE;
  assign or_val = working_q | file_rd;
  assign alu_res = is_inc ? inc_sum : (is_or ? or_val : file_rd);
  assign file_wdata = is_store ? working_q : alu_res;

  // software writes; an instruction in the same cycle takes priority
  assign sw_wr_working = reg_wr_i & (reg_addr_i == core_ops_pkg::REG_WORKING);
  assign sw_wr_status = reg_wr_i & (reg_addr_i == core_ops_pkg::REG_STATUS);

  // file register storage
  file_regs u_file_regs (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .rd_addr_i(file_addr_i),
    .rd_data_o(file_rd),
    .wr_en_i(to_file),
    .wr_addr_i(file_addr_i),
    .wr_data_i(file_wdata)
  );

  return_stack u_return_stack (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .push_i(call_push_i),
    .push_data_i(call_addr_i),
    .pop_i(pop),
    .top_of_stack_entry_o(stack_top)
  );

  // working register next value
  always_comb begin
    working_d = working_q;
    if (to_working) begin
      working_d = alu_res;
    end else if (is_load | is_ret_lit) begin
      working_d = literal_i;
    end else if (sw_wr_working) begin
      working_d = reg_wdata_i;
    end
  end

  // zero flag next value; the three destination ops set it, else a status register write loads it
  always_comb begin
    zero_d = zero_q;
    if (writes_result) begin
      zero_d = is_zero(alu_res);
    end else if (sw_wr_status) begin
      zero_d = reg_wdata_i[core_ops_pkg::STAT_ZERO_BIT];
    end
  end

  // interrupt enable: hardware set beats a software clear in the same cycle
  always_comb begin
    int_en_d = int_en_q;
    if (is_reti) begin
      int_en_d = 1'b1;
    end else if (sw_wr_status) begin
      int_en_d = reg_wdata_i[core_ops_pkg::STAT_INT_EN_BIT];
    end
  end

  // program counter and sequencer
  always_comb begin
    pc_d = pc_q;
    state_d = state_q;
    retire_d = 1'b0;
    unique case (state_q)
      core_ops_pkg::ST_EXEC: begin
        if (pop) begin
          pc_d = stack_top;
          state_d = core_ops_pkg::ST_FLUSH;
        end else if (accept) begin
          pc_d = pc_q + core_ops_pkg::PC_STEP;
          retire_d = 1'b1;
        end
      end
      core_ops_pkg::ST_FLUSH: begin
        // the fetched word after a return is discarded here
        state_d = core_ops_pkg::ST_EXEC;
        retire_d = 1'b1;
      end
      default: begin
        // illegal one-hot code recovers to execution
        state_d = core_ops_pkg::ST_EXEC;
      end
    endcase
  end

  // status view for the register port
  assign status_view = {{(core_ops_pkg::DATA_W - core_ops_pkg::STAT_BUSY_BIT - 1){1'b0}},
                        ~ready_q, int_en_q, zero_q};

  // read mux; data appear the cycle after the strobe, else zero
  always_comb begin
    rdata_d = core_ops_pkg::ZERO_BYTE;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        core_ops_pkg::REG_WORKING: rdata_d = working_q;
        core_ops_pkg::REG_STATUS: rdata_d = status_view;
        core_ops_pkg::REG_PC_LOW: rdata_d = pc_q[core_ops_pkg::DATA_W-1:0];
        core_ops_pkg::REG_PC_HIGH: rdata_d = {{(core_ops_pkg::DATA_W
                                               - core_ops_pkg::PC_HIGH_W){1'b0}},
                                              pc_q[core_ops_pkg::PC_W-1:core_ops_pkg::DATA_W]};
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_q <= core_ops_pkg::ST_EXEC;
      working_q <= core_ops_pkg::WORKING_RST;
      zero_q <= 1'b0;
      int_en_q <= 1'b0;
      pc_q <= core_ops_pkg::PC_RST;
      ready_q <= 1'b1;
      retire_q <= 1'b0;
      rdata_q <= core_ops_pkg::ZERO_BYTE;
    end else begin
      state_q <= state_d;
      working_q <= working_d;
      zero_q <= zero_d;
      int_en_q <= int_en_d;
      pc_q <= pc_d;
      ready_q <= (state_d == core_ops_pkg::ST_EXEC);
      retire_q <= retire_d;
      rdata_q <= rdata_d;
    end
  end

  // outputs come straight from flops
  assign instr_ready_o = ready_q;
  assign retire_o = retire_q;
  assign working_o = working_q;
  assign zero_o = zero_q;
  assign global_interrupt_enable_o = int_en_q;
  assign pc_o = pc_q;
  assign reg_rdata_o = rdata_q;

  // checks kept next to the logic they guard

  dest_route_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    writes_result |-> (to_file == dest_sel_i) && (to_working == !dest_sel_i))
    else $error("destination select routed wrong");

  incr_wrap_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (is_inc && !dest_sel_i) |=> (working_o == 8'($past(file_rd) + 8'h01))
      && (zero_o == ($past(file_rd) == 8'hff)))
    else $error("increment result or zero flag wrong");

  or_result_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (is_or && !dest_sel_i) |=> working_o == ($past(working_q) | $past(file_rd)))
    else $error("or result wrong");

  copy_zero_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (is_copy && dest_sel_i) |=> (zero_o == ($past(file_rd) == 8'h00))
      && (working_o == $past(working_q)))
    else $error("copy zero test wrong");

  literal_flags_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    is_load |=> (working_o == $past(literal_i)) && $stable(zero_o))
    else $error("literal load wrong");

  store_file_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    is_store |-> to_file && (file_wdata == working_q) && (zero_d == zero_q))
    else $error("store to file wrong");

  ret_lit_pc_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    is_ret_lit |=> (pc_o == $past(stack_top)) && (working_o == $past(literal_i))
      && $stable(zero_o))
    else $error("return with literal wrong");

  plain_return_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    is_ret |=> (pc_o == $past(stack_top)) && $stable(zero_o) && $stable(working_o))
    else $error("plain return wrong");

  return_cycles_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (is_ret || is_ret_lit) |=> !instr_ready_o && !retire_o ##1 instr_ready_o && retire_o)
    else $error("return not two cycles");

  reti_cycles_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    is_reti |=> !instr_ready_o && !retire_o ##1 instr_ready_o && retire_o)
    else $error("interrupt return not two cycles");

  // the flush cycle must neither take an instruction nor move the pc
  flush_hold_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !instr_ready_o |=> instr_ready_o && retire_o && $stable(pc_o))
    else $error("flush cycle took an instruction");

  reti_enable_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    is_reti |=> global_interrupt_enable_o && (pc_o == $past(stack_top)) && $stable(zero_o))
    else $error("interrupt return wrong");

endmodule : move_or_increment_return_ops

// File: bench/tb.sv
// self-checking bench for the instruction execution core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb;
  // clock and reset
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  // instruction issue
  logic instr_valid_i = 1'b0;
  logic [core_ops_pkg::OP_W-1:0] instr_op_i = '0;
  logic [core_ops_pkg::FILE_AW-1:0] file_addr_i = '0;
  logic dest_sel_i = 1'b0;
  logic [core_ops_pkg::DATA_W-1:0] literal_i = '0;
  logic instr_ready_o;
  logic retire_o;
  // stack push
  logic call_push_i = 1'b0;
  logic [core_ops_pkg::PC_W-1:0] call_addr_i = '0;
  // state outputs
  logic [core_ops_pkg::DATA_W-1:0] working_o;
  logic zero_o;
  logic global_interrupt_enable_o;
  logic [core_ops_pkg::PC_W-1:0] pc_o;
  // register port
  logic [core_ops_pkg::REG_AW-1:0] reg_addr_i = '0;
  logic [core_ops_pkg::DATA_W-1:0] reg_wdata_i = '0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [core_ops_pkg::DATA_W-1:0] reg_rdata_o;
  // bookkeeping
  int bad_count = 0;
  int compares = 0;
  logic [core_ops_pkg::PC_W-1:0] pc_e = '0; // expected program counter

  // half period of 10 ns gives 50 MHz
  always #10 clk_i = ~clk_i;

  move_or_increment_return_ops u_move_or_increment_return_ops (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .instr_valid_i(instr_valid_i), .instr_op_i(instr_op_i), .file_addr_i(file_addr_i),
    .dest_sel_i(dest_sel_i), .literal_i(literal_i), .instr_ready_o(instr_ready_o),
    .retire_o(retire_o), .call_push_i(call_push_i), .call_addr_i(call_addr_i),
    .working_o(working_o), .zero_o(zero_o),
    .global_interrupt_enable_o(global_interrupt_enable_o), .pc_o(pc_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o)
  );

  // verdict and end of run, shared by the tests and the watchdog
  task automatic test_done();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done

  // one instruction; returns expect pc_e set by the caller, others step it
  task automatic op(input logic [3:0] c, input logic [6:0] a, input logic d,
                    input logic [7:0] k, input logic [7:0] we, input logic ze);
    logic ret;
    ret = (c == core_ops_pkg::OP_RETURN_WITH_LITERAL) || (c == core_ops_pkg::OP_RETURN_PLAIN) ||
          (c == core_ops_pkg::OP_RETURN_FROM_INTERRUPT);
    if (!ret) begin
      pc_e = pc_e + core_ops_pkg::PC_STEP;
    end
    @(posedge clk_i);
    instr_valid_i <= 1'b1;
    instr_op_i <= c;
    file_addr_i <= a;
    dest_sel_i <= d;
    literal_i <= k;
    @(posedge clk_i);
    instr_valid_i <= 1'b0;
    #1;
    `CHK("working", we, working_o)
    `CHK("zero", ze, zero_o)
    `CHK("pc", pc_e, pc_o)
    // returns hold off issue one extra cycle before retiring
    if (ret) begin
      `CHK("ready in flush", 1'b0, instr_ready_o)
      `CHK("retire in flush", 1'b0, retire_o)
      @(posedge clk_i);
      #1;
    end
    `CHK("retire", 1'b1, retire_o)
    `CHK("ready", 1'b1, instr_ready_o)
  endtask : op

  // push a return address as the call logic would
  task automatic push(input logic [12:0] v);
    @(posedge clk_i);
    call_push_i <= 1'b1;
    call_addr_i <= v;
    @(posedge clk_i);
    call_push_i <= 1'b0;
  endtask : push

  // register port write, one strobe cycle
  task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write

  // register port read; data must stand one cycle only
  task automatic reg_read(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    `CHK("read data", e, reg_rdata_o)
    @(posedge clk_i);
    #1;
    `CHK("read idle", 8'h00, reg_rdata_o)
  endtask : reg_read

  // watchdog: the whole sequence needs well under 300 cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    test_done();
  end

  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    `CHK("reset working", 8'h00, working_o)
    `CHK("reset pc", 13'h0000, pc_o)
    `CHK("reset int enable", 1'b0, global_interrupt_enable_o)
    reg_read(core_ops_pkg::REG_STATUS, 8'h00);
    // preset zero so flag-preserving ops can be seen to leave it alone
    reg_write(core_ops_pkg::REG_STATUS, 8'h01);
    op(core_ops_pkg::OP_LOAD_LITERAL_TO_WORKING, 7'h00, 1'b0, 8'hff, 8'hff, 1'b1);
    op(core_ops_pkg::OP_STORE_WORKING_TO_FILE, 7'h7f, 1'b0, 8'h00, 8'hff, 1'b1);
    op(core_ops_pkg::OP_INCREMENT_FILE, 7'h7f, 1'b1, 8'h00, 8'hff, 1'b1);
    op(core_ops_pkg::OP_INCREMENT_FILE, 7'h7f, 1'b0, 8'h00, 8'h01, 1'b0);
    op(core_ops_pkg::OP_COPY_FILE_TO_DEST, 7'h7f, 1'b0, 8'h00, 8'h00, 1'b1);
    op(core_ops_pkg::OP_LOAD_LITERAL_TO_WORKING, 7'h00, 1'b0, 8'h5a, 8'h5a, 1'b1);
    op(core_ops_pkg::OP_STORE_WORKING_TO_FILE, 7'h00, 1'b0, 8'h00, 8'h5a, 1'b1);
    op(core_ops_pkg::OP_LOAD_LITERAL_TO_WORKING, 7'h00, 1'b0, 8'h81, 8'h81, 1'b1);
    op(core_ops_pkg::OP_OR_WORKING_INTO_FILE, 7'h00, 1'b0, 8'h00, 8'hdb, 1'b0);
    op(core_ops_pkg::OP_OR_WORKING_INTO_FILE, 7'h00, 1'b1, 8'h00, 8'hdb, 1'b0);
    op(core_ops_pkg::OP_COPY_FILE_TO_DEST, 7'h00, 1'b1, 8'h00, 8'hdb, 1'b0);
    op(core_ops_pkg::OP_COPY_FILE_TO_DEST, 7'h00, 1'b0, 8'h00, 8'hdb, 1'b0);
    op(core_ops_pkg::OP_LOAD_LITERAL_TO_WORKING, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0);
    op(core_ops_pkg::OP_OR_WORKING_INTO_FILE, 7'h05, 1'b0, 8'h00, 8'h00, 1'b1);
    // an unused code only steps the program counter
    op(4'hf, 7'h00, 1'b0, 8'h77, 8'h00, 1'b1);
    push(13'h1abc);
    push(13'h0123);
    push(13'h1fff);
    pc_e = 13'h1fff;
    op(core_ops_pkg::OP_RETURN_PLAIN, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1);
    pc_e = 13'h0123;
    op(core_ops_pkg::OP_RETURN_WITH_LITERAL, 7'h00, 1'b0, 8'hc3, 8'hc3, 1'b1);
    reg_read(core_ops_pkg::REG_PC_LOW, 8'h23);
    reg_read(core_ops_pkg::REG_PC_HIGH, 8'h01);
    `CHK("int enable before", 1'b0, global_interrupt_enable_o)
    pc_e = 13'h1abc;
    op(core_ops_pkg::OP_RETURN_FROM_INTERRUPT, 7'h00, 1'b0, 8'h00, 8'hc3, 1'b1);
    `CHK("int enable after", 1'b1, global_interrupt_enable_o)
    reg_read(core_ops_pkg::REG_STATUS, 8'h03);
    reg_read(core_ops_pkg::REG_PC_HIGH, 8'h1a);
    // pc view is read-only, a write must not move it
    reg_write(core_ops_pkg::REG_PC_LOW, 8'h00);
    reg_read(core_ops_pkg::REG_PC_LOW, 8'hbc);
    reg_write(core_ops_pkg::REG_WORKING, 8'h7e);
    reg_read(core_ops_pkg::REG_WORKING, 8'h7e);
    `CHK("working by port", 8'h7e, working_o)
    test_done();
  end
endmodule : tb
